// ---- verilog/fsr_pkg.sv ----
package fsr_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int IRQ_W  = 4;

   // Register offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_ADDR     = 8'h04;
   localparam logic [7:0] OFS_WDATA    = 8'h08;
   localparam logic [7:0] OFS_STATUS   = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_RDATA    = 8'h18;

   // STATUS fields
   localparam int ST_BUSY  = 0;
   localparam int ST_FAIL  = 1;
   localparam int ST_TIMER = 2;
   localparam int ST_RYBY  = 3;
   localparam int ST_REJ   = 4;

   // Interrupt fields
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_FAIL  = 1;
   localparam int IRQ_NACC  = 2;
   localparam int IRQ_RAISE = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

   // Status bit positions on the flash data pins
   localparam int DQ_POLL  = 7;
   localparam int DQ_TOG1  = 6;
   localparam int DQ_LIMIT = 5;
   localparam int DQ_TIMER = 3;
   localparam int DQ_TOG2  = 2;

   // Operation codes in CTRL[3:0]
   localparam logic [3:0] OP_READ    = 4'h0;
   localparam logic [3:0] OP_PROG    = 4'h1;
   localparam logic [3:0] OP_SECT    = 4'h2;
   localparam logic [3:0] OP_ADDSECT = 4'h3;
   localparam logic [3:0] OP_CHIP    = 4'h4;
   localparam logic [3:0] OP_WAIT    = 4'h5;
   localparam logic [3:0] OP_RESET   = 4'h6;
   localparam logic [3:0] OP_SUSPEND = 4'h7;
   localparam logic [3:0] OP_RESUME  = 4'h8;

   // Flash command words and unlock addresses
   localparam logic [ADDR_W-1:0] UNLOCK_A1 = 20'h00555;
   localparam logic [ADDR_W-1:0] UNLOCK_A2 = 20'h002aa;
   localparam logic [DATA_W-1:0] CMD_UNL1  = 16'h00aa;
   localparam logic [DATA_W-1:0] CMD_UNL2  = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_PROG  = 16'h00a0;
   localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0080;
   localparam logic [DATA_W-1:0] CMD_SECT  = 16'h0030;
   localparam logic [DATA_W-1:0] CMD_CHIP  = 16'h0010;
   localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;
   localparam logic [DATA_W-1:0] CMD_SUSP  = 16'h00b0;
   localparam logic [DATA_W-1:0] CMD_RESUM = 16'h0030;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_PULSE_NS    = 50;
   localparam int T_RECOV_NS    = 30;
   localparam int T_POLL_GAP_NS = 1000;
   localparam int PULSE_CYC     = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOV_CYC     = (T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POLL_GAP_CYC  = (T_POLL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fsr_flash_req_s;

   typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_RECOV} fsr_cyc_st_e;

   typedef enum logic [3:0] {
      S_IDLE, S_PRECHK, S_SEQ, S_POLL_A, S_POLL_B, S_POLL_C, S_POLL_D,
      S_GAP, S_TIMER_RD, S_ABORT, S_FINISH
   } fsr_ctl_st_e;
endpackage

// ---- verilog/fsr_gap_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsr_gap_timer
   import fsr_pkg::*;
#(
   parameter int CYC = POLL_GAP_CYC
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Control
   input  wire logic start,
   output logic      done
);
   typedef struct packed {
      logic        run;
      logic [15:0] cnt;
      logic        done;
   } fsr_gap_s;

   fsr_gap_s q, d;

   always_comb begin
      d      = q;
      d.done = 1'b0;
      if (start) begin
         d.run = 1'b1;
         d.cnt = 16'(CYC - 1);
      end else if (q.run) begin
         if (q.cnt == 16'h0000) begin
            d.run  = 1'b0;
            d.done = 1'b1;
         end else begin
            d.cnt = q.cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = q.done;
endmodule
`default_nettype wire

// ---- verilog/fsr_flash_cycle.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsr_flash_cycle
   import fsr_pkg::*;
#(
   parameter int PULSE = PULSE_CYC,
   parameter int RECOV = RECOV_CYC
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // Request
   input  wire logic              reqValid,
   input  wire fsr_flash_req_s    req,
   output logic                   done,
   output logic [DATA_W-1:0]      rdata,
   // Flash pins
   output logic [ADDR_W-1:0]      flashAddr,
   output logic [DATA_W-1:0]      flashDqOut,
   output logic                   flashDqOe,
   input  wire logic [DATA_W-1:0] flashDqIn,
   output logic                   flashCeN,
   output logic                   flashOeN,
   output logic                   flashWeN
);
   typedef struct packed {
      fsr_cyc_st_e       st;
      logic [7:0]        cnt;
      logic              write;
      logic              done;
      logic [DATA_W-1:0] rdata;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dqOut;
      logic              dqOe;
      logic              ceN;
      logic              oeN;
      logic              weN;
   } fsr_cyc_s;

   fsr_cyc_s q, d;

   always_comb begin
      d      = q;
      d.done = 1'b0;
      unique case (q.st)
         CY_IDLE: begin
            if (reqValid) begin
               d.addr  = req.addr;
               d.dqOut = req.data;
               d.write = req.write;
               d.dqOe  = req.write;
               d.ceN   = 1'b0;
               d.st    = CY_SETUP;
            end
         end
         CY_SETUP: begin
            d.weN = ~q.write;
            d.oeN = q.write;
            d.cnt = 8'(PULSE - 1);
            d.st  = CY_PULSE;
         end
         CY_PULSE: begin
            if (q.cnt == 8'h00) begin
               // Sampled while the output enable is still low
               d.rdata = flashDqIn;
               d.weN   = 1'b1;
               d.oeN   = 1'b1;
               d.cnt   = 8'(RECOV - 1);
               d.st    = CY_RECOV;
            end else begin
               d.cnt = q.cnt - 8'h01;
            end
         end
         CY_RECOV: begin
            d.ceN  = 1'b1;
            d.dqOe = 1'b0;
            if (q.cnt == 8'h00) begin
               d.done = 1'b1;
               d.st   = CY_IDLE;
            end else begin
               d.cnt = q.cnt - 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q     <= '0;
         q.st  <= CY_IDLE;
         q.ceN <= 1'b1;
         q.oeN <= 1'b1;
         q.weN <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign done       = q.done;
   assign rdata      = q.rdata;
   assign flashAddr  = q.addr;
   assign flashDqOut = q.dqOut;
   assign flashDqOe  = q.dqOe;
   assign flashCeN   = q.ceN;
   assign flashOeN   = q.oeN;
   assign flashWeN   = q.weN;
endmodule
`default_nettype wire

// ---- verilog/fsr_host_ctrl.sv ----
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module fsr_host_ctrl
   import fsr_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // Interrupt
   output logic                   irq,
   // Flash pins
   output logic [ADDR_W-1:0]      flashAddr,
   output logic [DATA_W-1:0]      flashDqOut,
   output logic                   flashDqOe,
   input  wire logic [DATA_W-1:0] flashDqIn,
   output logic                   flashCeN,
   output logic                   flashOeN,
   output logic                   flashWeN,
   input  wire logic              flashRyBy
);
   typedef struct packed {
      fsr_ctl_st_e       st;
      logic [3:0]        op;
      logic [2:0]        idx;
      logic              issued;
      logic              reqValid;
      fsr_flash_req_s    req;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic              togA;
      logic              gapStart;
      logic              fail;
      logic              timer;
      logic              rej;
      logic [IRQ_W-1:0]  irqStat;
      logic [IRQ_W-1:0]  irqMask;
      logic              irq;
      logic [31:0]       hrdata;
      logic              dphWrite;
      logic [7:0]        dphAddr;
   } fsr_ctl_s;

   fsr_ctl_s          q, d;
   logic              cycDone;
   logic [DATA_W-1:0] cycData;
   logic              gapDone;

   // Command word idx of the write sequence for an operation
   function automatic fsr_flash_req_s seqWord(input logic [3:0] op, input logic [2:0] idx,
                                              input logic [ADDR_W-1:0] a,
                                              input logic [DATA_W-1:0] w);
      fsr_flash_req_s r;
      r.write = 1'b1;
      r.addr  = (idx == 3'h1 || idx == 3'h4) ? UNLOCK_A2 : UNLOCK_A1;
      r.data  = (idx == 3'h1 || idx == 3'h4) ? CMD_UNL2 : CMD_UNL1;
      if (idx == 3'h2) begin
         r.data = (op == OP_PROG) ? CMD_PROG : CMD_ERASE;
      end
      if (op == OP_PROG && idx == 3'h3) begin
         r.addr = a;
         r.data = w;
      end
      if (idx == 3'h5) begin
         r.addr = (op == OP_CHIP) ? UNLOCK_A1 : a;
         r.data = (op == OP_CHIP) ? CMD_CHIP : CMD_SECT;
      end
      unique case (op)
         OP_ADDSECT: begin
            r.addr = a;
            r.data = CMD_SECT;
         end
         OP_RESET: begin
            r.addr = a;
            r.data = CMD_RESET;
         end
         OP_SUSPEND: begin
            r.addr = a;
            r.data = CMD_SUSP;
         end
         OP_RESUME: begin
            r.addr = a;
            r.data = CMD_RESUM;
         end
         default: begin
         end
      endcase
      return r;
   endfunction

   function automatic logic [2:0] seqLast(input logic [3:0] op);
      unique case (op)
         OP_PROG:             return 3'h3;
         OP_SECT, OP_CHIP:    return 3'h5;
         default:             return 3'h0;
      endcase
   endfunction

   always_comb begin
      logic [IRQ_W-1:0] evSet;
      logic [IRQ_W-1:0] evClr;
      logic             addrPh;
      logic             rdFlash;
      fsr_flash_req_s   rdReq;
      evSet       = '0;
      evClr       = '0;
      d           = q;
      d.reqValid  = 1'b0;
      d.gapStart  = 1'b0;
      addrPh      = hsel && htrans[1] && hready;
      rdFlash     = 1'b0;
      // Status reads always use the operation address, inside the busy sector
      rdReq.write = 1'b0;
      rdReq.addr  = q.addr;
      rdReq.data  = '0;

      unique case (q.st)
         S_IDLE: begin
         end
         S_PRECHK: begin
            rdFlash = 1'b1;
            if (q.issued && cycDone) begin
               d.rdata = cycData;
               d.st    = S_SEQ;
               if (q.op == OP_READ) begin
                  d.st = S_FINISH;
               end else if (q.op == OP_PROG && |(~cycData & q.wdata)) begin
                  // A 1 over a stored 0 cannot be programmed; expect a limit failure
                  evSet[IRQ_RAISE] = 1'b1;
               end else if (q.op == OP_ADDSECT && cycData[DQ_TIMER]) begin
                  // Window already closed: the device would ignore the command
                  d.timer          = 1'b1;
                  evSet[IRQ_NACC]  = 1'b1;
                  d.st             = S_FINISH;
               end
            end
         end
         S_SEQ: begin
            if (!q.issued) begin
               d.reqValid = 1'b1;
               d.req      = seqWord(q.op, q.idx, q.addr, q.wdata);
               d.issued   = 1'b1;
            end else if (cycDone) begin
               d.issued = 1'b0;
               d.idx    = q.idx + 3'h1;
               if (q.idx == seqLast(q.op)) begin
                  unique case (q.op)
                     OP_PROG, OP_CHIP, OP_SECT: d.st = S_POLL_A;
                     OP_ADDSECT:                d.st = S_TIMER_RD;
                     default:                   d.st = S_FINISH;
                  endcase
               end
            end
         end
         S_POLL_A: begin
            rdFlash = 1'b1;
            if (q.issued && cycDone) begin
               d.togA = cycData[DQ_TOG1];
               d.st   = S_POLL_B;
            end
         end
         S_POLL_B: begin
            rdFlash = 1'b1;
            if (q.issued && cycDone) begin
               d.rdata = cycData;
               if (cycData[DQ_TOG1] == q.togA) begin
                  // Not toggling: operation over, or erase never accepted
                  if (q.op == OP_SECT) begin
                     evSet[IRQ_NACC] = 1'b1;
                  end
                  d.st = S_FINISH;
               end else if (q.op == OP_SECT) begin
                  d.st = S_TIMER_RD;
               end else if (cycData[DQ_LIMIT]) begin
                  d.st = S_POLL_C;
               end else begin
                  d.gapStart = 1'b1;
                  d.st       = S_GAP;
               end
            end
         end
         S_POLL_C: begin
            rdFlash = 1'b1;
            if (q.issued && cycDone) begin
               d.togA = cycData[DQ_TOG1];
               d.st   = S_POLL_D;
            end
         end
         S_POLL_D: begin
            rdFlash = 1'b1;
            if (q.issued && cycDone) begin
               d.rdata = cycData;
               // Toggle may stop just as the limit flag rises, hence the recheck
               if (cycData[DQ_TOG1] == q.togA) begin
                  d.st = S_FINISH;
               end else begin
                  d.fail           = 1'b1;
                  evSet[IRQ_FAIL]  = 1'b1;
                  d.op             = OP_RESET;
                  d.idx            = 3'h0;
                  d.st             = S_ABORT;
               end
            end
         end
         S_GAP: begin
            if (gapDone) begin
               d.st = S_POLL_A;
            end
         end
         S_TIMER_RD: begin
            rdFlash = 1'b1;
            if (q.issued && cycDone) begin
               d.rdata = cycData;
               d.timer = cycData[DQ_TIMER];
               // Window closed after an added sector: it may have been dropped
               if (q.op == OP_ADDSECT && cycData[DQ_TIMER]) begin
                  evSet[IRQ_NACC] = 1'b1;
               end
               d.st = S_FINISH;
            end
         end
         S_ABORT: begin
            if (!q.issued) begin
               d.reqValid = 1'b1;
               d.req      = seqWord(OP_RESET, 3'h0, q.addr, q.wdata);
               d.issued   = 1'b1;
            end else if (cycDone) begin
               d.issued = 1'b0;
               d.st     = S_FINISH;
            end
         end
         S_FINISH: begin
            evSet[IRQ_DONE] = 1'b1;
            d.st            = S_IDLE;
         end
      endcase

      // Shared single read issue for the precheck, polling and timer-read states
      if (rdFlash) begin
         if (!q.issued) begin
            d.reqValid = 1'b1;
            d.req      = rdReq;
            d.issued   = 1'b1;
         end else if (cycDone) begin
            d.issued = 1'b0;
         end
      end

      // Bus data phase: writes land here
      if (q.dphWrite) begin
         unique case (q.dphAddr)
            OFS_CTRL: begin
               if (q.st != S_IDLE) begin
                  d.rej = 1'b1;
               end else begin
                  d.op    = hwdata[3:0];
                  d.idx   = 3'h0;
                  d.fail  = 1'b0;
                  d.rej   = 1'b0;
                  d.st    = (hwdata[3:0] == OP_READ || hwdata[3:0] == OP_PROG ||
                             hwdata[3:0] == OP_ADDSECT) ? S_PRECHK :
                            (hwdata[3:0] == OP_WAIT) ? S_POLL_A : S_SEQ;
                  d.timer = 1'b0;
               end
            end
            OFS_ADDR:     d.addr    = hwdata[ADDR_W-1:0];
            OFS_WDATA:    d.wdata   = hwdata[DATA_W-1:0];
            OFS_IRQ_MASK: d.irqMask = hwdata[IRQ_W-1:0];
            default: begin
            end
         endcase
      end

      // Bus address phase: read data is prepared for the next cycle
      d.dphWrite = addrPh && hwrite;
      d.dphAddr  = haddr[7:0];
      if (addrPh && !hwrite) begin
         d.hrdata = 32'h0000_0000;
         unique case (haddr[7:0])
            OFS_ADDR:     d.hrdata[ADDR_W-1:0] = q.addr;
            OFS_WDATA:    d.hrdata[DATA_W-1:0] = q.wdata;
            OFS_RDATA:    d.hrdata[DATA_W-1:0] = q.rdata;
            OFS_IRQ_MASK: d.hrdata[IRQ_W-1:0]  = q.irqMask;
            OFS_IRQ_STAT: begin
               d.hrdata[IRQ_W-1:0] = q.irqStat;
               evClr               = q.irqStat;
            end
            OFS_STATUS: begin
               d.hrdata[ST_BUSY]  = (q.st != S_IDLE);
               d.hrdata[ST_FAIL]  = q.fail;
               d.hrdata[ST_TIMER] = q.timer;
               d.hrdata[ST_RYBY]  = flashRyBy;
               d.hrdata[ST_REJ]   = q.rej;
            end
            default: begin
            end
         endcase
      end

      // A new event wins over a read-clear in the same cycle
      d.irqStat = (q.irqStat & ~evClr) | evSet;
      d.irq     = |(d.irqStat & d.irqMask);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q         <= '0;
         q.st      <= S_IDLE;
         q.irqMask <= IRQ_MASK_RST;
      end else begin
         q <= d;
      end
   end

   fsr_flash_cycle u_cycle (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .reqValid   (q.reqValid),
      .req        (q.req),
      .done       (cycDone),
      .rdata      (cycData),
      .flashAddr  (flashAddr),
      .flashDqOut (flashDqOut),
      .flashDqOe  (flashDqOe),
      .flashDqIn  (flashDqIn),
      .flashCeN   (flashCeN),
      .flashOeN   (flashOeN),
      .flashWeN   (flashWeN)
   );

   // Polls are paced so the host never hammers a busy part
   fsr_gap_timer u_gap (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (q.gapStart),
      .done    (gapDone)
   );

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = q.hrdata;
   assign irq       = q.irq;
endmodule
`default_nettype wire

// ---- verif/fsr_host_ctrl_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsr_host_ctrl_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Bus and flash strobes
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic flashDqOe,
   input wire logic flashCeN,
   input wire logic flashOeN,
   input wire logic flashWeN
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait OKAY");
   strobe_excl_a: assert property (flashWeN || flashOeN)
      else $error("write and read strobes both low");
   drive_read_a: assert property (flashDqOe |-> flashOeN)
      else $error("data driven during a read");
   we_width_a: assert property ($fell(flashWeN) |-> !flashWeN[*5] ##1 flashWeN)
      else $error("write strobe width wrong");
   oe_width_a: assert property ($fell(flashOeN) |-> !flashOeN[*5] ##1 flashOeN)
      else $error("read strobe width wrong");
   chip_sel_a: assert property (!flashWeN || !flashOeN |-> !flashCeN)
      else $error("strobe without chip enable");
   write_cover_c: cover property ($fell(flashWeN));
   read_cover_c: cover property ($fell(flashOeN));
   drive_cover_c: cover property (flashDqOe);
endmodule
bind fsr_host_ctrl fsr_host_ctrl_asserts chk_u (.ref_clk(ref_clk), .rst(rst),
   .hreadyout(hreadyout), .hresp(hresp), .flashDqOe(flashDqOe),
   .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN));
`default_nettype wire

// ---- verif/fsr_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsr_flash_model
   import fsr_pkg::*;
(
   // Clock and reset
   input wire logic              ref_clk,
   input wire logic              rst,
   // Flash pins
   input wire logic [ADDR_W-1:0] flashAddr,
   input wire logic [DATA_W-1:0] flashDqOut,
   input wire logic              flashOeN,
   input wire logic              flashWeN,
   output logic [DATA_W-1:0]     flashDqIn,
   output logic                  flashRyBy,
   output int                    resetCnt
);
   logic [DATA_W-1:0] mem [16];
   logic [DATA_W-1:0] v, lastV;
   logic              prevWe, prevOe, pendProg, fail, tog, erase, susp;
   logic [3:0]        a;
   int                busy, rdCnt;
   assign a = flashAddr[3:0];
   always_comb begin
      v = mem[a];
      if (busy > 0 && !susp) begin
         v[DQ_POLL] = erase ? 1'b0 : ~mem[a][DQ_POLL];
         v[DQ_TOG1] = tog;
         v[DQ_LIMIT] = fail;
         v[DQ_TIMER] = erase && rdCnt >= 5;
         v[DQ_TOG2] = erase ? tog : mem[a][DQ_TOG2];
      end
      // Released bus shows the inverse so stale data cannot pass
      flashDqIn = flashOeN ? ~lastV : v;
      flashRyBy = busy == 0 || susp;
   end
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {prevWe, prevOe, pendProg, fail, tog, erase, susp} <= 7'h60;
         {busy, rdCnt, resetCnt} <= '0;
         lastV <= '0;
         foreach (mem[i]) mem[i] <= 16'hffff;
      end else begin
         prevWe <= flashWeN;
         prevOe <= flashOeN;
         if (!prevOe && flashOeN) begin
            lastV <= v;
            tog <= ~tog;
            rdCnt <= rdCnt + 1;
            if (busy > 0 && !fail && !susp) busy <= busy - 1;
         end
         // Busy device takes reset only after a failure, and otherwise only suspend, resume or an added sector during an erase
         if (!prevWe && flashWeN) begin
            if (flashDqOut == CMD_RESET && (busy == 0 || fail)) begin
               {busy, fail, pendProg} <= '0;
               resetCnt <= resetCnt + 1;
            end else if (susp && flashDqOut == CMD_RESUM) begin
               susp <= 1'b0;
            end else if (busy > 0 && erase && flashDqOut == CMD_SUSP) begin
               susp <= 1'b1;
            end else if (busy > 0 && erase && rdCnt < 5 && flashDqOut == CMD_SECT) begin
               {busy, rdCnt} <= {32'd6, 32'd0};
            end else if (busy == 0 && pendProg) begin
               mem[a] <= mem[a] & flashDqOut;
               fail <= |(flashDqOut & ~mem[a]);
               {busy, erase, pendProg} <= {32'd3, 2'b00};
            end else if (busy == 0 && flashDqOut == CMD_PROG) begin
               pendProg <= 1'b1;
            end else if (busy == 0 && flashDqOut inside {CMD_SECT, CMD_CHIP}) begin
               // Chip erase starts with the window already closed
               {busy, rdCnt, erase} <= {32'd6, (flashDqOut == CMD_CHIP) ? 32'd5 : 32'd0, 1'b1};
               foreach (mem[i]) mem[i] <= 16'hffff;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/fsr_host_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsr_host_ctrl_test;
   import fsr_pkg::*;
   logic              ref_clk, rst, hsel, hwrite, hreadyout, hresp, irq;
   logic              flashDqOe, flashCeN, flashOeN, flashWeN, flashRyBy;
   logic [31:0]       haddr, hwdata, hrdata, rv;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [ADDR_W-1:0] flashAddr;
   logic [DATA_W-1:0] flashDqOut, flashDqIn;
   int                miscompares, check_count, cycles, resetCnt;
   fsr_host_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .irq(irq), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
      .flashDqOe(flashDqOe), .flashDqIn(flashDqIn), .flashCeN(flashCeN),
      .flashOeN(flashOeN), .flashWeN(flashWeN), .flashRyBy(flashRyBy));
   fsr_flash_model model_u (.ref_clk(ref_clk), .rst(rst), .flashAddr(flashAddr),
      .flashDqOut(flashDqOut), .flashOeN(flashOeN), .flashWeN(flashWeN),
      .flashDqIn(flashDqIn), .flashRyBy(flashRyBy), .resetCnt(resetCnt));
   initial begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Address phase held until hready, then data phase until hready
   task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
      @(posedge ref_clk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, wr, 24'h0, ofs};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task automatic run(input logic [3:0] op);
      bus(1'b1, OFS_CTRL, {28'h0, op});
      repeat (400) begin
         bus(1'b0, OFS_STATUS, 32'h0);
         if (rv[ST_BUSY] === 1'b0) break;
      end
      chk({31'h0, rv[ST_BUSY]}, 32'h0);
   endtask
   task automatic t_reset;
      bus(1'b0, OFS_IRQ_MASK, 32'h0);
      chk(rv, 32'h0);
      bus(1'b0, 8'h1c, 32'h0);
      chk(rv, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk({31'h0, rv[ST_RYBY]}, 32'h1);
      $display("reset test done");
   endtask
   task automatic t_prog;
      bus(1'b1, OFS_IRQ_MASK, 32'hf);
      bus(1'b1, OFS_ADDR, 32'h1);
      bus(1'b1, OFS_WDATA, 32'h1234);
      run(OP_PROG);
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rv, 32'h1);
      chk({31'h0, irq}, 32'h0);
      run(OP_READ);
      bus(1'b0, OFS_RDATA, 32'h0);
      chk(rv, 32'h1234);
      $display("program test done");
   endtask
   task automatic t_fail;
      bus(1'b1, OFS_WDATA, 32'hffff);
      run(OP_PROG);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk({31'h0, rv[ST_FAIL]}, 32'h1);
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rv, 32'hb);
      chk(resetCnt, 1);
      $display("limit failure test done");
   endtask
   task automatic t_erase;
      run(OP_SECT);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk({31'h0, rv[ST_TIMER]}, 32'h0);
      run(OP_ADDSECT);
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rv, 32'h1);
      run(OP_SUSPEND);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk({31'h0, rv[ST_RYBY]}, 32'h1);
      run(OP_READ);
      bus(1'b0, OFS_RDATA, 32'h0);
      chk(rv, 32'hffff);
      run(OP_RESUME);
      // Reads age the model's window so that the next add is refused
      repeat (3) run(OP_READ);
      run(OP_ADDSECT);
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rv, 32'h5);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk({31'h0, rv[ST_TIMER]}, 32'h1);
      run(OP_WAIT);
      run(OP_READ);
      bus(1'b0, OFS_RDATA, 32'h0);
      chk(rv, 32'hffff);
      $display("erase test done");
   endtask
   task automatic t_chip;
      bus(1'b1, OFS_WDATA, 32'h00ff);
      run(OP_PROG);
      bus(1'b1, OFS_CTRL, {28'h0, OP_CHIP});
      run(OP_READ);
      chk({31'h0, rv[ST_REJ]}, 32'h1);
      run(OP_READ);
      bus(1'b0, OFS_RDATA, 32'h0);
      chk(rv, 32'hffff);
      run(OP_RESET);
      chk(resetCnt, 2);
      $display("chip erase test done");
   endtask
   initial begin
      {rst, hsel, hwrite, htrans, haddr, hwdata, hsize} = {3'b100, 66'h0, 3'h2};
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_prog();
      t_fail();
      t_erase();
      t_chip();
      test_done();
   end
endmodule
`default_nettype wire
